// *** uir_pkg.sv ***
// Constants for the serial port interrupt and register block.
// Assumes byte addresses on a 32-bit register port.
package uir_pkg;
	// ------------------------------------------------------------
	// Address map
	// ------------------------------------------------------------
	localparam logic [31:0] BASE_ADDR   = 32'h4030_0000;
	localparam int          PAGE_LSB    = 8;
	localparam logic [7:0]  OFS_DATA    = 8'h00;
	localparam logic [7:0]  OFS_RSTAT   = 8'h04;
	localparam logic [7:0]  OFS_TMO     = 8'h0c;
	localparam logic [7:0]  OFS_FLAGS   = 8'h18;
	localparam logic [7:0]  OFS_RXLC    = 8'h1c;
	localparam logic [7:0]  OFS_BAUDI   = 8'h24;
	localparam logic [7:0]  OFS_BAUDF   = 8'h28;
	localparam logic [7:0]  OFS_TXLC    = 8'h2c;
	localparam logic [7:0]  OFS_CTRL    = 8'h30;
	localparam logic [7:0]  OFS_WMSEL   = 8'h34;
	localparam logic [7:0]  OFS_MASK    = 8'h38;
	localparam logic [7:0]  OFS_RAW     = 8'h3c;
	localparam logic [7:0]  OFS_MSKD    = 8'h40;
	localparam logic [7:0]  OFS_ICLR    = 8'h44;
	localparam logic [7:0]  OFS_DMA     = 8'h48;
	localparam logic [7:0]  OFS_SWFC    = 8'h50;
	localparam logic [7:0]  OFS_RES_A   = 8'h54;
	localparam logic [7:0]  OFS_RES_B   = 8'h58;
	localparam logic [7:0]  OFS_PAU_A   = 8'h5c;
	localparam logic [7:0]  OFS_PAU_B   = 8'h60;
	localparam int          NUM_WORDS   = 25;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [31:0] TMO_RST     = 32'h0000_01ff;
	localparam logic [31:0] FLAGS_RST   = 32'h0000_1e90;
	localparam logic [31:0] CTRL_RST    = 32'h0004_0300;
	localparam logic [31:0] WMSEL_RST   = 32'h0000_0012;

	// ------------------------------------------------------------
	// Fields
	// ------------------------------------------------------------
	localparam int          IRQ_TX      = 5;
	localparam int          IRQ_RT      = 6;
	localparam int          IRQ_FE      = 7;
	localparam int          IRQ_PE      = 8;
	localparam int          IRQ_BE      = 9;
	localparam int          IRQ_OE      = 10;
	localparam int          IRQ_W       = 11;
	localparam int          ST_FE       = 0;
	localparam int          ST_OE       = 3;
	localparam int          FIFO_EN_BIT = 4;
	localparam int          PORT_EN_BIT = 0;
	localparam int          TMO_W       = 22;
	localparam int          FLAGS_W     = 13;
	localparam int          LVL_W       = 5;
	localparam int          RXTOP_W     = 12;

	typedef logic [LVL_W-1:0] uir_lvl_t;

	// Transmit watermark per select code, 16-entry FIFO
	function automatic uir_lvl_t uir_wm(input logic [2:0] sel);
		case (sel)
			3'h0:    uir_wm = 5'h02;
			3'h1:    uir_wm = 5'h04;
			3'h2:    uir_wm = 5'h08;
			3'h3:    uir_wm = 5'h0c;
			default: uir_wm = 5'h0e;
		endcase
	endfunction : uir_wm
endpackage : uir_pkg

// *** uir_regs.sv ***
// Interrupt generation and register map of the serial port.
// Assumes a datapath that reports fill levels and receive events
// synchronously to core_clk, and a bit-rate enable pulse.
//
// Behaviour
// - FIFO mode: tx irq on watermark crossing
// - Single mode: tx irq when location empty
// - Tx irq set by transition, never initially
// - Single mode accepts write while holding busy
// - Single mode: next write clears tx irq
// - Receive timeout when idle and non-empty
// - Timeout clears on empty or clear write
// - Receive errors raise readable error causes
// - Clear register bits clear error causes
// - Any error clear write resets error flags
// - Status read and error clear share 0x04
// - Timeout period at 0x0c, reset 0x1ff
// - Flags at 0x18, reset 0x1e90
// - Watermark select at 0x34, reset 0x12
// - Masked status is raw and mask
// - Interrupt clear at 0x44, write-only
// - Four flow characters at 0x54-0x60
// - Decode relative to peripheral base address
// - Mask bit enables source onto irq
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module uir_regs (
	input  wire logic                        core_clk,
	input  wire logic                        sys_rst,
	input  wire logic [31:0]                 reg_addr,
	input  wire logic [31:0]                 reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [31:0]                 reg_rdata,
	input  wire logic                        bit_tick,
	input  wire uir_pkg::uir_lvl_t           tx_level,
	input  wire logic                        tx_drained,
	input  wire uir_pkg::uir_lvl_t           rx_level,
	input  wire logic [uir_pkg::RXTOP_W-1:0] rx_top,
	input  wire logic                        rx_push,
	input  wire logic [2:0]                  rx_err,
	input  wire logic                        rx_overrun,
	input  wire logic                        rx_start,
	input  wire logic [uir_pkg::FLAGS_W-1:0] line_flags_in,
	output logic                             tx_push,
	output logic      [7:0]                  tx_push_data,
	output logic                             rx_pop,
	output logic                             fifo_en,
	output logic                             port_en,
	output logic                             irq
);
	import uir_pkg::*;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	function automatic logic is_rw(input logic [4:0] idx);
		logic [7:0] ofs;
		ofs = {1'b0, idx, 2'b00};
		is_rw = (ofs == OFS_TMO)   || (ofs == OFS_RXLC)  ||
		        (ofs == OFS_BAUDI) || (ofs == OFS_BAUDF) ||
		        (ofs == OFS_TXLC)  || (ofs == OFS_CTRL)  ||
		        (ofs == OFS_WMSEL) || (ofs == OFS_MASK)  ||
		        (ofs == OFS_DMA)   || (ofs == OFS_SWFC)  ||
		        (ofs == OFS_RES_A) || (ofs == OFS_RES_B) ||
		        (ofs == OFS_PAU_A) || (ofs == OFS_PAU_B);
	endfunction : is_rw

	function automatic logic [31:0] rst_val(input logic [4:0] idx);
		logic [7:0] ofs;
		ofs = {1'b0, idx, 2'b00};
		if (ofs == OFS_TMO)
			rst_val = TMO_RST;
		else if (ofs == OFS_CTRL)
			rst_val = CTRL_RST;
		else if (ofs == OFS_WMSEL)
			rst_val = WMSEL_RST;
		else
			rst_val = 32'h0000_0000;
	endfunction : rst_val

	logic [31:0] cfg_q [NUM_WORDS];
	logic [7:0]  ofs;
	logic [4:0]  idx;
	logic        page_hit;
	logic        hit;
	logic        wr_data;
	logic        rd_data;
	logic        wr_eclr;
	logic        wr_iclr;

	assign ofs      = reg_addr[7:0];
	assign idx      = ofs[6:2];
	assign page_hit = reg_addr[31:PAGE_LSB] == BASE_ADDR[31:PAGE_LSB];
	assign hit      = page_hit && (ofs[1:0] == 2'b00) && !ofs[7];
	assign wr_data  = reg_wr && hit && (ofs == OFS_DATA);
	assign rd_data  = reg_rd && hit && (ofs == OFS_DATA);
	assign wr_eclr  = reg_wr && hit && (ofs == OFS_RSTAT);
	assign wr_iclr  = reg_wr && hit && (ofs == OFS_ICLR);

	// ------------------------------------------------------------
	// Plain read-write registers
	// ------------------------------------------------------------
	for (genvar g = 0; g < NUM_WORDS; g++) begin : g_cfg
		if (is_rw(5'(g))) begin : g_rw
			always_ff @(posedge core_clk or posedge sys_rst) begin
				if (sys_rst)
					cfg_q[g] <= rst_val(5'(g));
				else if (reg_wr && hit && idx == 5'(g))
					cfg_q[g] <= reg_wdata;
			end
		end else begin : g_none
			assign cfg_q[g] = 32'h0000_0000;
		end
	end

	logic [31:0] mask;
	logic [2:0]  wm_sel;
	logic [TMO_W-1:0] tmo_period;

	assign mask       = cfg_q[OFS_MASK[6:2]];
	assign wm_sel     = cfg_q[OFS_WMSEL[6:2]][2:0];
	assign tmo_period = cfg_q[OFS_TMO[6:2]][TMO_W-1:0];
	assign fifo_en    = cfg_q[OFS_TXLC[6:2]][FIFO_EN_BIT];
	assign port_en    = cfg_q[OFS_CTRL[6:2]][PORT_EN_BIT];

	// ------------------------------------------------------------
	// Transmit interrupt
	// ------------------------------------------------------------
	logic     below_p_q;
	uir_lvl_t tx_thr;
	logic     tx_below;
	logic     tx_above;
	logic     tx_set;
	logic     tx_clr;

	assign tx_thr   = uir_wm(wm_sel);
	assign tx_below = tx_level < tx_thr;
	assign tx_above = tx_level > tx_thr;
	// Edge on the crossing, so an idle empty FIFO never fires
	assign tx_set   = fifo_en ? (tx_below && !below_p_q)
	                          : tx_drained;
	// Single mode: a data write lands in the bottom entry even
	// while the holding register still shifts
	assign tx_clr   = fifo_en ? tx_above
	                          : wr_data;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			below_p_q <= 1'b1;
		else
			below_p_q <= tx_below;
	end

	// ------------------------------------------------------------
	// Receive timeout
	// ------------------------------------------------------------
	logic [TMO_W-1:0] rt_cnt_q;
	logic [TMO_W-1:0] rt_cnt_d;
	logic             rx_busy;
	logic             rx_act;
	logic             rt_full;
	logic             rt_set;

	assign rx_busy  = rx_level != '0;
	assign rx_act   = rx_push || rx_start || !rx_busy;
	assign rt_full  = rt_cnt_q == tmo_period;
	assign rt_set   = bit_tick && rx_busy && !rx_act && !rt_full &&
	                  (rt_cnt_q + 1'b1 == tmo_period);
	assign rt_cnt_d = rx_act ? '0 :
	                  (bit_tick && !rt_full) ? rt_cnt_q + 1'b1 : rt_cnt_q;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			rt_cnt_q <= '0;
		else
			rt_cnt_q <= rt_cnt_d;
	end

	// ------------------------------------------------------------
	// Raw and masked interrupt status
	// ------------------------------------------------------------
	logic [IRQ_W-1:0] ris_q;
	logic [IRQ_W-1:0] ris_d;
	logic [IRQ_W-1:0] set_vec;
	logic [IRQ_W-1:0] clr_vec;
	logic [IRQ_W-1:0] icr_vec;
	logic [IRQ_W-1:0] irq_masked_status;

	// Only ones in the clear word act
	assign icr_vec = wr_iclr ? reg_wdata[IRQ_W-1:0] : '0;

	always_comb begin
		set_vec         = '0;
		set_vec[IRQ_TX] = tx_set;
		set_vec[IRQ_RT] = rt_set;
		set_vec[IRQ_FE] = rx_push && rx_err[0];
		set_vec[IRQ_PE] = rx_push && rx_err[1];
		set_vec[IRQ_BE] = rx_push && rx_err[2];
		set_vec[IRQ_OE] = rx_overrun;
		clr_vec         = icr_vec;
		clr_vec[IRQ_TX] = icr_vec[IRQ_TX] || tx_clr;
		clr_vec[IRQ_RT] = icr_vec[IRQ_RT] || !rx_busy;
	end

	// A set in the cycle of its clear wins
	assign ris_d = (ris_q & ~clr_vec) | set_vec;
	assign irq_masked_status   = ris_q & mask[IRQ_W-1:0];

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ris_q <= '0;
			irq   <= 1'b0;
		end else begin
			ris_q <= ris_d;
			irq   <= |(ris_d & mask[IRQ_W-1:0]);
		end
	end

	// ------------------------------------------------------------
	// Receive status, error clear by any write
	// ------------------------------------------------------------
	logic [ST_OE:ST_FE] rst_q;
	logic [ST_OE:ST_FE] rst_d;

	assign rst_d = (wr_eclr ? '0 : rst_q) |
	               ({rx_overrun, rx_err} & {1'b1, {3{rx_push}}});

	// Line flags mirror the datapath one cycle late
	logic [31:0] flags_q;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rst_q   <= '0;
			flags_q <= FLAGS_RST;
		end else begin
			rst_q   <= rst_d;
			flags_q <= {{(32-FLAGS_W){1'b0}}, line_flags_in};
		end
	end

	// ------------------------------------------------------------
	// Read mux and datapath strobes
	// ------------------------------------------------------------
	logic [31:0] fix_word;
	logic [31:0] rd_word;

	assign fix_word =
		(ofs == OFS_DATA)  ? {{(32-RXTOP_W){1'b0}}, rx_top} :
		(ofs == OFS_RSTAT) ? {28'h0, rst_q} :
		(ofs == OFS_FLAGS) ? flags_q :
		(ofs == OFS_RAW)   ? {{(32-IRQ_W){1'b0}}, ris_q} :
		(ofs == OFS_MSKD)  ? {{(32-IRQ_W){1'b0}}, irq_masked_status} :
		32'h0000_0000;
	assign rd_word = !hit ? 32'h0000_0000 :
	                 is_rw(idx) ? cfg_q[idx] : fix_word;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata    <= '0;
			tx_push      <= 1'b0;
			tx_push_data <= '0;
			rx_pop       <= 1'b0;
		end else begin
			reg_rdata    <= reg_rd ? rd_word : '0;
			tx_push      <= wr_data;
			tx_push_data <= wr_data ? reg_wdata[7:0] : tx_push_data;
			rx_pop       <= rd_data && rx_busy;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	sequence s_mis_read;
		reg_rd && hit && ofs == OFS_MSKD;
	endsequence

	sequence s_idle_tick;
		bit_tick && rx_busy && !rx_act && rt_cnt_q + 1'b1 == tmo_period;
	endsequence

	a_tx_cross_set: assert property (
		fifo_en && tx_below && !below_p_q |=> ris_q[IRQ_TX])
		else $error("tx irq missed watermark crossing");
	a_tx_drain_set: assert property (
		!fifo_en && tx_drained |=> ris_q[IRQ_TX])
		else $error("tx irq missed empty location");
	a_tx_rise_cause: assert property (
		!ris_q[IRQ_TX] ##1 ris_q[IRQ_TX] |->
		$past(fifo_en ? tx_below && !below_p_q : tx_drained))
		else $error("tx irq rose without a crossing");
	a_tx_write_clr: assert property (
		!fifo_en && wr_data && !tx_drained |=> !ris_q[IRQ_TX] && tx_push)
		else $error("tx irq survived a data write");
	a_rt_timeout: assert property (
		s_idle_tick ##0 !rt_full |=> ris_q[IRQ_RT])
		else $error("timeout irq missed");
	a_rt_empty_clr: assert property (
		!rx_busy |=> !ris_q[IRQ_RT])
		else $error("timeout irq held with empty fifo");
	a_err_cause: assert property (
		rx_push && rx_err[0] |=> ris_q[IRQ_FE] && rst_q[ST_FE])
		else $error("framing error not reported");
	a_eclr_any: assert property (
		wr_eclr && !rx_push && !rx_overrun |=> rst_q == '0)
		else $error("error flags survived clear");
	a_mis_gate: assert property (
		s_mis_read |=> reg_rdata[IRQ_W-1:0] ==
		($past(ris_q) & $past(mask[IRQ_W-1:0])))
		else $error("masked status mismatch");
	a_icr_zero: assert property (
		wr_iclr && reg_wdata[IRQ_W-1:0] == '0 && !tx_clr && rx_busy |=>
		(ris_q | ~$past(ris_q)) == '1)
		else $error("zero clear write dropped a status bit");
	a_irq_mask: assert property (
		(ris_q & mask[IRQ_W-1:0]) == '0 ##1
		(ris_q & mask[IRQ_W-1:0]) == '0 |-> !irq)
		else $error("irq without an enabled source");
endmodule : uir_regs

// *** uir_line_model.sv ***
// Far side of the serial port: fill counts, drain and bit pulses.
// Assumes the bench requests each drain with one-cycle tx_send.
`timescale 1ns/1ps
module uir_line_model (
	input  wire logic                        core_clk,
	input  wire logic                        sys_rst,
	input  wire logic                        tx_push,
	input  wire logic                        tx_send,
	input  wire logic                        rx_push,
	input  wire logic                        rx_pop,
	input  wire logic [2:0]                  rx_err,
	input  wire logic [7:0]                  rx_char,
	output logic                             bit_tick,
	output logic                             tx_drained,
	output uir_pkg::uir_lvl_t                tx_level,
	output uir_pkg::uir_lvl_t                rx_level,
	output logic      [uir_pkg::RXTOP_W-1:0] rx_top
);
	import uir_pkg::*;
	logic [1:0] div_q;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_q <= 2'h0;
			bit_tick <= 1'b0;
			tx_drained <= 1'b0;
			tx_level <= '0;
			rx_level <= '0;
			rx_top <= '0;
		end else begin
			div_q <= div_q + 2'h1;
			bit_tick <= (div_q == 2'h3);
			tx_drained <= tx_send && (tx_level != '0);
			tx_level <= tx_level + LVL_W'(tx_push)
				- LVL_W'(tx_send && (tx_level != '0));
			rx_level <= rx_level + LVL_W'(rx_push)
				- LVL_W'(rx_pop && (rx_level != '0));
			if (rx_push)
				rx_top <= {1'b0, rx_err, rx_char};
			else if (rx_level == '0)
				rx_top <= ~rx_top;  // Empty: stale entry inverted every cycle
		end
	end
endmodule : uir_line_model

// *** test_uir_regs.sv ***
// Self-checking bench for the serial port register block.
// Assumes uir_line_model stands in for the datapath.
`timescale 1ns/1ps
module test_uir_regs;
	import uir_pkg::*;
	logic core_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
	logic rx_push = 0, rx_overrun = 0, rx_start = 0, tx_send = 0;
	logic bit_tick, tx_drained, tx_push, rx_pop, fifo_en, port_en, irq;
	logic [31:0] reg_addr = 0, reg_wdata = 0, reg_rdata, rv;
	logic [2:0] rx_err = 0;
	logic [7:0] rx_char = 0, tx_push_data;
	logic [FLAGS_W-1:0] line_flags_in = FLAGS_RST[FLAGS_W-1:0];
	logic [RXTOP_W-1:0] rx_top;
	uir_lvl_t tx_level, rx_level;
	int n_errors = 0, cmp_count = 0, cyc = 0;

	always #2.5 core_clk = ~core_clk;

	uir_regs u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .bit_tick(bit_tick),
		.tx_level(tx_level), .tx_drained(tx_drained),
		.rx_level(rx_level), .rx_top(rx_top), .rx_push(rx_push),
		.rx_err(rx_err), .rx_overrun(rx_overrun), .rx_start(rx_start),
		.line_flags_in(line_flags_in), .tx_push(tx_push),
		.tx_push_data(tx_push_data), .rx_pop(rx_pop),
		.fifo_en(fifo_en), .port_en(port_en), .irq(irq));
	uir_line_model u_line (.core_clk(core_clk), .sys_rst(sys_rst),
		.tx_push(tx_push), .tx_send(tx_send), .rx_push(rx_push),
		.rx_pop(rx_pop), .rx_err(rx_err), .rx_char(rx_char),
		.bit_tick(bit_tick), .tx_drained(tx_drained),
		.tx_level(tx_level), .rx_level(rx_level), .rx_top(rx_top));

	function automatic logic [31:0] A(input logic [7:0] o);
		return BASE_ADDR | {24'h0, o};
	endfunction : A
	function automatic logic [31:0] f_err(input int i);
		return 32'h1 << (IRQ_FE + i);
	endfunction : f_err

	task automatic complete_run;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("FAIL %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic pulse_rx(input logic [2:0] e, input logic ov);
		@(posedge core_clk);
		rx_push <= !ov;
		rx_overrun <= ov;
		rx_err <= e;
		rx_char <= 8'($urandom);
		@(posedge core_clk);
		rx_push <= 1'b0;
		rx_overrun <= 1'b0;
	endtask : pulse_rx
	task automatic send;
		@(posedge core_clk);
		tx_send <= 1'b1;
		@(posedge core_clk);
		tx_send <= 1'b0;
	endtask : send
	task automatic wait_rt;
		rv = 0;
		for (int k = 0; k < 40 && rv[IRQ_RT] !== 1'b1; k++)
			rd(A(OFS_RAW), rv);
	endtask : wait_rt

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			complete_run();
		end
	end

	initial begin
		logic [7:0] ro[9];
		logic [31:0] ex[9], m, d;
		logic [2:0] e;
		ro = '{OFS_TMO, OFS_FLAGS, OFS_CTRL, OFS_WMSEL, OFS_RES_A,
			OFS_PAU_B, OFS_ICLR, OFS_RAW, 8'h08};
		ex = '{TMO_RST, FLAGS_RST, CTRL_RST, WMSEL_RST, 0, 0, 0, 0, 0};
		rv = $urandom(18767);
		repeat (5) @(posedge core_clk);
		sys_rst <= 1'b0;
		// ------------------------------------------------------------
		// Reset values, decode and storage
		// ------------------------------------------------------------
		foreach (ro[i]) begin
			rd(A(ro[i]), rv);
			chk(rv, ex[i]);
		end
		wr(A(OFS_TMO) ^ 32'h100, $urandom);
		rd(A(OFS_TMO) ^ 32'h100, rv);
		chk(rv, 0);
		rd(A(OFS_TMO), rv);
		chk(rv, TMO_RST);
		for (int i = 0; i < 4; i++) begin
			d = $urandom;
			wr(A(OFS_RES_A + 8'(4 * i)), d);
			rd(A(OFS_RES_A + 8'(4 * i)), rv);
			chk(rv, d);
		end
		@(posedge core_clk);
		line_flags_in <= FLAGS_W'($urandom);
		rd(A(OFS_FLAGS), rv);
		chk(rv, 32'(line_flags_in));
		// ------------------------------------------------------------
		// Error causes, masking and clears
		// ------------------------------------------------------------
		for (int i = 0; i < 4; i++) begin
			e = (i < 3) ? 3'(1 << i) : 3'h0;
			pulse_rx(e, i == 3);
			rd(A(OFS_RAW), rv);
			chk(rv, f_err(i));
			m = $urandom & 32'h7e0;
			wr(A(OFS_MASK), m);
			rd(A(OFS_MSKD), rv);
			chk(rv, f_err(i) & m);
			chk(32'(irq), 32'(|(f_err(i) & m)));
			rd(A(OFS_RSTAT), rv);
			chk(rv, 32'h1 << i);
			wr(A(OFS_ICLR), 32'h0);
			wr(A(OFS_ICLR), ~f_err(i));
			rd(A(OFS_RAW), rv);
			chk(rv, f_err(i));
			wr(A(OFS_ICLR), f_err(i));
			rd(A(OFS_RAW), rv);
			chk(rv, 0);
			if (i < 3) begin
				d = {20'h0, 1'b0, e, rx_char};
				rd(A(OFS_DATA), rv);
				chk(rv, d);
				chk(32'(rx_pop), 1);
			end
			wr(A(OFS_RSTAT), $urandom);
			rd(A(OFS_RSTAT), rv);
			chk(rv, 0);
		end
		// ------------------------------------------------------------
		// Receive timeout
		// ------------------------------------------------------------
		wr(A(OFS_TMO), 32'h4);
		for (int j = 0; j < 2; j++) begin
			pulse_rx(3'h0, 1'b0);
			// Start bits keep restarting the idle count
			repeat (j * 12) begin
				@(posedge core_clk);
				rx_start <= 1'b1;
				@(posedge core_clk);
				rx_start <= 1'b0;
			end
			rd(A(OFS_RAW), rv);
			chk(rv & 32'h40, 0);
			wait_rt();
			chk(rv & 32'h40, 32'h40);
			if (j == 0)
				rd(A(OFS_DATA), rv);
			else
				wr(A(OFS_ICLR), 32'h40);
			// Pop reaches the fill count a cycle later, the status a cycle after
			repeat (2) @(posedge core_clk);
			rd(A(OFS_RAW), rv);
			chk(rv, 0);
		end
		rd(A(OFS_DATA), rv);
		// ------------------------------------------------------------
		// Transmit interrupt, single location then FIFO mode
		// ------------------------------------------------------------
		wr(A(OFS_MASK), 32'h20);
		wr(A(OFS_CTRL), CTRL_RST | 32'h1);
		rd(A(OFS_RAW), rv);
		chk(rv, 0);
		chk(32'(port_en), 1);
		d = $urandom & 32'hff;
		wr(A(OFS_DATA), d);
		send();
		rd(A(OFS_RAW), rv);
		chk(rv, 32'h20);
		chk(32'(irq), 1);
		wr(A(OFS_DATA), d ^ 32'h5a);
		rd(A(OFS_RAW), rv);
		chk(rv, 0);
		chk(32'(tx_push_data), d ^ 32'h5a);
		chk(32'(tx_level), 1);
		send();
		wr(A(OFS_ICLR), 32'h20);
		rd(A(OFS_RAW), rv);
		chk(rv, 0);
		wr(A(OFS_TXLC), 32'h10);
		wr(A(OFS_WMSEL), 32'h0);
		chk(32'(fifo_en), 1);
		repeat (3) wr(A(OFS_DATA), $urandom & 32'hff);
		send();
		rd(A(OFS_RAW), rv);
		chk(rv, 0);
		send();
		rd(A(OFS_RAW), rv);
		chk(rv, 32'h20);
		repeat (2) wr(A(OFS_DATA), $urandom & 32'hff);
		// Fill count lags the push by a cycle
		repeat (2) @(posedge core_clk);
		rd(A(OFS_RAW), rv);
		chk(rv, 0);
		complete_run();
	end
endmodule : test_uir_regs
